// ### hw/pat_firing_ctrl.sv
// Functional notes
// - only falling zero-cross edge starts a wave
// - first full wave measures period into register
// - prescale 64 makes count one full cycle
// - prescale 32 makes same count half cycle
// - at crossing load phase delay, count down
// - delay expiry reloads half value, first pulse
// - half value is period corrected by table
// - period averaged over sixteen waves
// - after averaging sample pot, ramp, recompute
// - half count expiry fires second pulse
// - after second pulse reload 255 and count
// - next crossing stores elapsed remainder interval
// - full wave is remainder plus half plus phase
// - speed becomes firing delay through table
// - phase is upper byte of period times speed
// - speed table holds sixty-four levels
`timescale 1ns/1ps
`default_nettype none
module pat_firing_ctrl #(
  parameter int BASE_DIV = pat_pkg::BASE_DIV,
  parameter int PULSE_CYCLES = pat_pkg::PULSE_CYCLES
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // mains and gate
  input wire logic zeroCross,
  output logic gateOut,
  // speed potentiometer adc
  output logic adcStart,
  input wire logic adcDone,
  input wire logic [7:0] adcData,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  localparam logic [11:0] PULSE_RST = 12'(PULSE_CYCLES);
  localparam logic [7:0] BASE_LAST = 8'(BASE_DIV - 1);
  localparam logic [15:0] GAP_FULL = 16'((int'(pat_pkg::PRESC_FULL_MAX) + 1) * BASE_DIV - 1);
  localparam logic [15:0] GAP_HALF = 16'((int'(pat_pkg::PRESC_HALF_MAX) + 1) * BASE_DIV - 1);

  // speed lookup: 64 levels, higher level gives shorter delay
  function automatic logic [7:0] speedLookup(input logic [5:0] level);
    speedLookup = 8'hfc - {level, 2'b00};
  endfunction

  // oscillator compensation, indexed by top phase bits
  function automatic logic [7:0] compensate(input logic [7:0] period, input logic [2:0] idx);
    logic [7:0] corr;
    corr = 8'h00;
    unique case (idx)
      3'h0, 3'h1: corr = 8'h00;
      3'h2, 3'h3, 3'h4: corr = 8'h01;
      3'h5, 3'h6, 3'h7: corr = 8'h02;
    endcase
    compensate = (period > corr) ? period - corr : 8'h01;
  endfunction

  pat_pkg::pat_state_e state_q, state_d;
  logic [1:0] zcSync_q;
  logic zcPrev_q;
  logic [7:0] baseCnt_q;
  logic [5:0] prescCnt_q;
  logic [15:0] tickGap_q;
  logic [7:0] counter_q, counter_d;
  logic counterLoad;
  logic [7:0] mainsPeriod_q, compHalf_q, phase_q, remainder_q;
  logic periodValid_q;
  logic [13:0] accum_q;
  logic [3:0] waveCnt_q;
  logic adcStart_q, adcBusy_q, update_q;
  logic [7:0] speedTarget_q;
  logic [5:0] speedLevel_q;
  logic [11:0] pulseCnt_q, pulseLen_q, gateRun_q;
  logic fireEnable_q;
  logic ack_q;
  logic [31:0] readdata_q;

  // zero-cross edge detect on synchronised pin
  wire zcLevel = zcSync_q[1];
  wire zcEvent = zcPrev_q & ~zcLevel;
  // time base: prescaler 64 while measuring, 32 while firing
  wire measuring = (state_q == pat_pkg::ST_MEASURE);
  wire [5:0] prescMax = measuring ? pat_pkg::PRESC_FULL_MAX : pat_pkg::PRESC_HALF_MAX;
  wire baseTick = (baseCnt_q == BASE_LAST);
  wire unitTick = baseTick & (prescCnt_q == prescMax);
  wire expire = unitTick & (counter_q <= 8'h01);
  wire [7:0] elapsed = pat_pkg::CAPTURE_LOAD - counter_q;
  // full wave in half-rate units and running average
  wire [7:0] remainder_d = elapsed;
  wire [9:0] fullWave = {2'b00, remainder_d} + {2'b00, compHalf_q} + {2'b00, phase_q};
  wire [13:0] accumNext = accum_q + {4'h0, fullWave};
  wire [7:0] avgPeriod = accumNext[13] ? 8'hff : accumNext[12:5];
  wire waveEnd = zcEvent & (state_q == pat_pkg::ST_CAPTURE);
  wire avgDone = waveEnd & (waveCnt_q == pat_pkg::AVG_LAST);
  wire firstDone = zcEvent & measuring;
  // speed path: ramp one level per update toward pot
  wire [5:0] potLevel = speedTarget_q[7:2];
  wire [5:0] rampLevel = (speedLevel_q < potLevel) ? speedLevel_q + 6'h01 :
                         (speedLevel_q > potLevel) ? speedLevel_q - 6'h01 : speedLevel_q;
  wire [7:0] speedRef = speedLookup(rampLevel);
  wire [15:0] product = {8'h00, mainsPeriod_q} * {8'h00, speedRef};
  wire [7:0] phaseNew = product[15:8];
  // gate pulse launch
  wire fire1 = (state_q == pat_pkg::ST_DELAY) & expire;
  wire fire2 = (state_q == pat_pkg::ST_HALF) & expire;
  wire fireNow = (fire1 | fire2) & periodValid_q & fireEnable_q;

  // sequence next state and counter reloads
  always_comb
  begin
    state_d = state_q;
    counter_d = counter_q;
    counterLoad = 1'b0;
    unique case (state_q)
      pat_pkg::ST_WAIT_FIRST:
        if (zcEvent)
        begin
          state_d = pat_pkg::ST_MEASURE;
          counter_d = pat_pkg::CAPTURE_LOAD;
          counterLoad = 1'b1;
        end
      pat_pkg::ST_MEASURE:
        if (zcEvent)
          state_d = pat_pkg::ST_WAIT_ZC;
      pat_pkg::ST_WAIT_ZC, pat_pkg::ST_DELAY, pat_pkg::ST_HALF, pat_pkg::ST_CAPTURE:
        if (zcEvent)
        begin
          state_d = pat_pkg::ST_DELAY;
          counter_d = phase_q;
          counterLoad = 1'b1;
        end
        else if (fire1)
        begin
          state_d = pat_pkg::ST_HALF;
          counter_d = compHalf_q;
          counterLoad = 1'b1;
        end
        else if (fire2)
        begin
          state_d = pat_pkg::ST_CAPTURE;
          counter_d = pat_pkg::CAPTURE_LOAD;
          counterLoad = 1'b1;
        end
      default:
        state_d = pat_pkg::ST_WAIT_FIRST;
    endcase
  end

  // synchroniser, state and phase counter
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      zcSync_q <= 2'b11;
      zcPrev_q <= 1'b1;
      state_q <= pat_pkg::ST_WAIT_FIRST;
      counter_q <= 8'h00;
      baseCnt_q <= 8'h00;
      prescCnt_q <= 6'h00;
      tickGap_q <= 16'h0000;
    end
    else if (clockEnable)
    begin
      zcSync_q <= {zcSync_q[0], zeroCross};
      zcPrev_q <= zcLevel;
      state_q <= state_d;
      baseCnt_q <= (counterLoad | baseTick) ? 8'h00 : baseCnt_q + 8'h01;
      prescCnt_q <= counterLoad ? 6'h00 : (unitTick ? 6'h00 : prescCnt_q + 6'(baseTick));
      tickGap_q <= (unitTick | counterLoad) ? 16'h0000 : tickGap_q + 16'h0001;
      if (counterLoad)
        counter_q <= counter_d;
      else if (unitTick && counter_q != 8'h00)
        counter_q <= counter_q - 8'h01;
    end
  end

  // period, remainder and averaging
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      mainsPeriod_q <= 8'h00;
      remainder_q <= 8'h00;
      periodValid_q <= 1'b0;
      accum_q <= 14'h0000;
      waveCnt_q <= 4'h0;
    end
    else if (clockEnable)
    begin
      if (firstDone)
      begin
        mainsPeriod_q <= elapsed;
        periodValid_q <= 1'b1;
      end
      if (waveEnd)
      begin
        remainder_q <= remainder_d;
        waveCnt_q <= waveCnt_q + 4'h1;
        accum_q <= avgDone ? 14'h0000 : accumNext;
        if (avgDone)
          mainsPeriod_q <= avgPeriod;
      end
    end
  end

  // adc sample, ramp, phase and compensated half value
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      adcStart_q <= 1'b0;
      adcBusy_q <= 1'b0;
      update_q <= 1'b0;
      speedTarget_q <= 8'h00;
      speedLevel_q <= 6'h00;
      phase_q <= 8'h00;
      compHalf_q <= 8'h00;
    end
    else if (clockEnable)
    begin
      adcStart_q <= (avgDone | firstDone) & ~adcBusy_q;
      adcBusy_q <= adcStart_q | (adcBusy_q & ~adcDone);
      if (adcBusy_q && adcDone)
        speedTarget_q <= adcData;
      update_q <= adcBusy_q & adcDone;
      if (update_q)
      begin
        speedLevel_q <= rampLevel;
        phase_q <= phaseNew;
        compHalf_q <= compensate(mainsPeriod_q, phaseNew[7:5]);
      end
    end
  end
  assign adcStart = adcStart_q;

  // gate pulse width counter
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pulseCnt_q <= 12'h000;
      gateRun_q <= 12'h000;
    end
    else if (clockEnable)
    begin
      pulseCnt_q <= fireNow ? pulseLen_q : (pulseCnt_q != 12'h000 ? pulseCnt_q - 12'h001 : 12'h000);
      gateRun_q <= gateOut ? gateRun_q + 12'h001 : 12'h000;
    end
  end
  assign gateOut = (pulseCnt_q != 12'h000);

  // avalon slave: one wait cycle, then answer
  wire access = read | write;
  wire regHit = (address[5] == 1'b0) & (address[1:0] == 2'b00);
  wire doWrite = write & ack_q & regHit;
  wire [31:0] statusWord = {27'h0, periodValid_q, 1'b0, state_q};
  wire [31:0] readMux =
    ~regHit ? 32'h0 :
    (address == pat_pkg::REG_CTRL) ? {31'h0, fireEnable_q} :
    (address == pat_pkg::REG_PULSE) ? {20'h0, pulseLen_q} :
    (address == pat_pkg::REG_STATUS) ? statusWord :
    (address == pat_pkg::REG_PERIOD) ? {24'h0, mainsPeriod_q} :
    (address == pat_pkg::REG_COMP) ? {24'h0, compHalf_q} :
    (address == pat_pkg::REG_PHASE) ? {24'h0, phase_q} :
    (address == pat_pkg::REG_REMAIN) ? {24'h0, remainder_q} :
    {16'h0, speedTarget_q, 2'b00, speedLevel_q};

  // bus handshake and software registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0;
      fireEnable_q <= pat_pkg::CTRL_FIRE_EN_RST;
      pulseLen_q <= PULSE_RST;
    end
    else if (clockEnable)
    begin
      ack_q <= access & ~ack_q;
      if (read && !ack_q)
        readdata_q <= readMux;
      if (doWrite && address == pat_pkg::REG_CTRL)
        fireEnable_q <= writedata[pat_pkg::CTRL_FIRE_EN_BIT];
      if (doWrite && address == pat_pkg::REG_PULSE)
        pulseLen_q <= writedata[11:0];
    end
  end
  assign waitrequest = access & ~ack_q;
  assign readdata = readdata_q;

  // checks
  property p_rise_ignored;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (!zcPrev_q && zcLevel && !fire1 && !fire2) |=> $stable(state_q);
  endproperty
  a_rise_ignored: assert property (p_rise_ignored) else $error("rising edge started a wave");

  property p_no_fire_early;
    @(posedge clock) disable iff (!reset_n)
      !periodValid_q |-> ##1 !gateOut;
  endproperty
  a_no_fire_early: assert property (p_no_fire_early) else $error("gate pulse before period known");

  property p_pulse_len;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      $fell(gateOut) |-> $past(gateRun_q) == $past(pulseLen_q, 2) - 12'h001;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("gate pulse width wrong");

  property p_first_fire;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (fire1 && !zcEvent) |=> state_q == pat_pkg::ST_HALF && counter_q == $past(compHalf_q);
  endproperty
  a_first_fire: assert property (p_first_fire) else $error("half value not loaded");

  property p_capture_load;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (fire2 && !zcEvent) |=> state_q == pat_pkg::ST_CAPTURE && counter_q == 8'hff;
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture not started at 255");

  property p_remainder;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      waveEnd |=> remainder_q == 8'hff - $past(counter_q);
  endproperty
  a_remainder: assert property (p_remainder) else $error("remainder interval wrong");

  property p_phase_load;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (zcEvent && state_q != pat_pkg::ST_WAIT_FIRST && !measuring) |=>
        state_q == pat_pkg::ST_DELAY && counter_q == $past(phase_q);
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("phase delay not loaded");

  property p_phase_calc;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      update_q |=> phase_q == $past(product[15:8]);
  endproperty
  a_phase_calc: assert property (p_phase_calc) else $error("phase not upper product byte");

  property p_prescale;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (unitTick && state_q != pat_pkg::ST_WAIT_FIRST && state_q != pat_pkg::ST_WAIT_ZC) |->
        tickGap_q == (measuring ? GAP_FULL : GAP_HALF);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale ratio wrong");

  property p_avg_adc;
    @(posedge clock) disable iff (!reset_n || !clockEnable)
      (avgDone && !adcBusy_q) |=> adcStart && mainsPeriod_q == $past(avgPeriod);
  endproperty
  a_avg_adc: assert property (p_avg_adc) else $error("average or adc sample missing");
endmodule
`default_nettype wire

// ### hw/pat_pkg.sv
`default_nettype none
package pat_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int UNIT_TIME_NS = 1250;
  localparam int BASE_DIV = UNIT_TIME_NS / CLK_PERIOD_NS;
  localparam int PULSE_TIME_NS = 10000;
  localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] PRESC_FULL_MAX = 6'h3f;
  localparam logic [5:0] PRESC_HALF_MAX = 6'h1f;
  localparam logic [7:0] CAPTURE_LOAD = 8'hff;
  localparam logic [3:0] AVG_LAST = 4'hf;
  // register map, byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_PULSE = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h08;
  localparam logic [5:0] REG_PERIOD = 6'h0c;
  localparam logic [5:0] REG_COMP = 6'h10;
  localparam logic [5:0] REG_PHASE = 6'h14;
  localparam logic [5:0] REG_REMAIN = 6'h18;
  localparam logic [5:0] REG_SPEED = 6'h1c;
  // field positions and reset values
  localparam int CTRL_FIRE_EN_BIT = 0;
  localparam int STATUS_VALID_BIT = 4;
  localparam logic CTRL_FIRE_EN_RST = 1'b1;
  // firing sequence states
  typedef enum logic [2:0] {
    ST_WAIT_FIRST = 3'b000,
    ST_MEASURE = 3'b001,
    ST_WAIT_ZC = 3'b010,
    ST_DELAY = 3'b011,
    ST_HALF = 3'b100,
    ST_CAPTURE = 3'b101
  } pat_state_e;
endpackage
`default_nettype wire

// ### testbench/pat_mains_model.sv
`timescale 1ns/1ps
`default_nettype none
module pat_mains_model #(
  parameter int WAVE_CLKS = 3072,
  parameter logic [7:0] POT = 8'hc8
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // mains side
  output logic zeroCross,
  // potentiometer adc side
  input wire logic adcStart,
  output logic adcDone,
  output logic [7:0] adcData
);
  int phaseCnt = 0;
  logic [1:0] busyCnt;
  // free running mains wave, the low half starts at the negative crossing
  always_ff @(posedge clock)
  begin
    phaseCnt <= (phaseCnt >= WAVE_CLKS - 1) ? 0 : phaseCnt + 1;
  end
  assign zeroCross = (phaseCnt < WAVE_CLKS / 2);
  // slow conversion; data line shows garbage while no result is offered
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      busyCnt <= 2'h0;
    else if (adcStart)
      busyCnt <= 2'h3;
    else if (busyCnt != 2'h0)
      busyCnt <= busyCnt - 2'h1;
  end
  assign adcDone = (busyCnt == 2'h1);
  assign adcData = adcDone ? POT : ~POT;
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int WAVE = 3100;
  localparam logic [7:0] POT = 8'hc8;
  localparam int PER = WAVE / 128;
  logic clock, reset_n, clockEnable, zeroCross, gateOut, adcStart, adcDone;
  logic read, write, waitrequest;
  logic [7:0] adcData;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rd, lvl, ph, hf, rm, sum;
  int error_cnt = 0;
  int total_checks = 0;
  int hiCnt = 0;
  int pulseCnt = 0;
  int lastWidth = 0;
  int p0;
  pat_firing_ctrl #(.BASE_DIV(2), .PULSE_CYCLES(400)) pat_firing_ctrl_i (.clock(clock),
    .reset_n(reset_n), .clockEnable(clockEnable), .zeroCross(zeroCross), .gateOut(gateOut),
    .adcStart(adcStart), .adcDone(adcDone), .adcData(adcData), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
  pat_mains_model #(.WAVE_CLKS(WAVE), .POT(POT)) pat_mains_model_i (.clock(clock),
    .reset_n(reset_n), .zeroCross(zeroCross), .adcStart(adcStart), .adcDone(adcDone),
    .adcData(adcData));
  // clock generation
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // gate pulse counter and width of the last pulse
  always @(posedge clock)
  begin
    if (gateOut === 1'b1)
      hiCnt <= hiCnt + 1;
    else if (hiCnt != 0)
    begin
      lastWidth <= hiCnt;
      hiCnt <= 0;
      pulseCnt <= pulseCnt + 1;
    end
  end
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clock);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
    input string what);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, what);
  endtask
  task automatic waves(input int n);
    repeat (n) @(negedge zeroCross);
  endtask
  // compensation correction by the top bits of the phase
  function automatic logic [7:0] corr(input logic [2:0] idx);
    return (idx < 3'h2) ? 8'h00 : (idx < 3'h5) ? 8'h01 : 8'h02;
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog against a hung run
  initial
  begin
    #(90000 * 25);
    error_cnt++;
    $display("ERROR at %0t: watchdog expired", $time);
    final_report();
  end
  // test sequence
  initial
  begin
    reset_n = 1'b0;
    clockEnable = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rchk(pat_pkg::REG_CTRL, 32'h1, 32'h1, "fire enable reset");
    rchk(pat_pkg::REG_PULSE, 32'hfff, 32'h190, "pulse length reset");
    rchk(pat_pkg::REG_STATUS, 32'h10, 32'h0, "valid at reset");
    rchk(6'h20, 32'hffffffff, 32'h0, "unmapped read");
    bus(1'b1, 6'h20, 32'hffffffff);
    bus(1'b1, pat_pkg::REG_PERIOD, 32'h5a);
    bus(1'b1, pat_pkg::REG_PULSE, 32'h4);
    $display("test registers done");
    waves(2);
    chk(pulseCnt, 0, "pulse before measurement");
    waves(2);
    rchk(pat_pkg::REG_STATUS, 32'h10, 32'h10, "period valid");
    rchk(pat_pkg::REG_PERIOD, 32'hff, PER, "measured period");
    rchk(pat_pkg::REG_SPEED, 32'hff00, {16'h0, POT, 8'h0}, "pot sample");
    lvl = rd & 32'h3f;
    bus(1'b0, pat_pkg::REG_PHASE, 32'h0);
    ph = rd;
    chk(ph, (PER * (252 - 4 * lvl)) >> 8, "phase delay");
    rchk(pat_pkg::REG_COMP, 32'hff, PER - corr(ph[7:5]), "compensated half");
    hf = rd;
    $display("test measurement done");
    p0 = pulseCnt;
    waves(4);
    chk(pulseCnt - p0, 8, "two pulses per wave");
    chk(lastWidth, 4, "pulse width");
    bus(1'b0, pat_pkg::REG_REMAIN, 32'h0);
    rm = rd & 32'hff;
    sum = rm + hf + ph;
    chk(sum >= 2 * PER - 2 && sum <= 2 * PER + 2, 1, "full wave sum");
    $display("test firing done");
    waves(16);
    rchk(pat_pkg::REG_PERIOD, 32'hff, PER, "averaged period");
    rchk(pat_pkg::REG_SPEED, 32'h3f, lvl + 1, "ramp step");
    $display("test averaging done");
    bus(1'b1, pat_pkg::REG_CTRL, 32'h0);
    p0 = pulseCnt;
    waves(2);
    chk(pulseCnt - p0, 0, "pulses while disabled");
    $display("test disable done");
    // freeze: with the enable low a request stays unanswered
    @(posedge clock);
    clockEnable <= 1'b0;
    address <= pat_pkg::REG_PERIOD;
    read <= 1'b1;
    repeat (5) @(posedge clock);
    chk(waitrequest, 1, "answer while frozen");
    clockEnable <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    chk(rd & 32'hff, PER, "read after freeze");
    $display("test freeze done");
    final_report();
  end
endmodule
`default_nettype wire
